/* File: common/bos_pkg.sv */
// shared constants, opcode map and decode helpers for the byte-op executor
package bos_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned INSN_W  = 12;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned PC_W    = 11;
  localparam int unsigned JMP_W   = 9;
  localparam int unsigned PAGE_W  = 2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned FLD_F_LSB   = 0;
  localparam int unsigned FLD_DEST    = 5;
  localparam int unsigned FLD_OP6_LSB = 6;
  localparam int unsigned FLD_OP4_LSB = 8;
  localparam int unsigned FLD_OP3_LSB = 9;
  localparam int unsigned FLD_K_LSB   = 0;

  // ****************************************************************
  // opcode patterns
  // ****************************************************************
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECREMENT  = 6'h03;
  localparam logic [5:0] OPC_INCREMENT  = 6'h0A;
  localparam logic [5:0] OPC_DEC_SKIP   = 6'h0B;
  localparam logic [5:0] OPC_INC_SKIP   = 6'h0F;
  localparam logic [2:0] OPC_JUMP       = 3'h5;
  localparam logic [3:0] OPC_OR_LIT     = 4'hD;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic              ZERO_RST = 1'b0;
  localparam logic [PC_W-1:0]   PC_RST   = 11'h000;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_COMPLEMENT,
    OP_DECREMENT,
    OP_INCREMENT,
    OP_DEC_SKIP,
    OP_INC_SKIP,
    OP_JUMP,
    OP_OR_LIT
  } bos_op_t;

  function automatic bos_op_t bos_decode(input logic [INSN_W-1:0] w);
    bos_op_t r;
    r = OP_NONE;
    case (w[INSN_W-1:FLD_OP6_LSB])
      OPC_COMPLEMENT: r = OP_COMPLEMENT;
      OPC_DECREMENT:  r = OP_DECREMENT;
      OPC_INCREMENT:  r = OP_INCREMENT;
      OPC_DEC_SKIP:   r = OP_DEC_SKIP;
      OPC_INC_SKIP:   r = OP_INC_SKIP;
      default:        r = OP_NONE;
    endcase
    if (w[INSN_W-1:FLD_OP3_LSB] == OPC_JUMP) r = OP_JUMP;
    if (w[INSN_W-1:FLD_OP4_LSB] == OPC_OR_LIT) r = OP_OR_LIT;
    return r;
  endfunction : bos_decode

  function automatic logic bos_is_file_op(input bos_op_t op);
    return (op == OP_COMPLEMENT) || (op == OP_DECREMENT) ||
           (op == OP_INCREMENT) || (op == OP_DEC_SKIP) ||
           (op == OP_INC_SKIP);
  endfunction : bos_is_file_op

  function automatic logic bos_is_skip_op(input bos_op_t op);
    return (op == OP_DEC_SKIP) || (op == OP_INC_SKIP);
  endfunction : bos_is_skip_op

endpackage : bos_pkg

/* File: core/bos_alu.sv */
// byte arithmetic for the executor: complement, step and literal or
`timescale 1ns/10ps
`default_nettype none
module bos_alu
  import bos_pkg::*;
(
  // operation and operands
  input  wire logic [2:0]        op,
  input  wire logic [DATA_W-1:0] file_val,
  input  wire logic [DATA_W-1:0] acc_val,
  input  wire logic [DATA_W-1:0] literal,
  // result
  output logic      [DATA_W-1:0] result,
  output logic                   is_zero
);

  bos_op_t op_e;

  always_comb begin
    op_e = bos_op_t'(op);
    case (op_e)
      OP_COMPLEMENT: result = ~file_val;
      OP_DECREMENT,
      OP_DEC_SKIP:   result = file_val - 8'h01;
      OP_INCREMENT,
      OP_INC_SKIP:   result = file_val + 8'h01;
      OP_OR_LIT:     result = acc_val | literal;
      default:       result = file_val;
    endcase
    is_zero = (result == 8'h00);
  end

endmodule : bos_alu
`default_nettype wire

/* File: core/bos_seq.sv */
// flow control for the executor: branch target and slot discard
`timescale 1ns/10ps
`default_nettype none
module bos_seq
  import bos_pkg::*;
(
  // executing operation
  input  wire logic [2:0]        op,
  input  wire logic              res_zero,
  input  wire logic [JMP_W-1:0]  jump_k,
  input  wire logic [PAGE_W-1:0] page,
  // flow decisions
  output logic                   take_jump,
  output logic                   flush_next,
  output logic      [PC_W-1:0]   target
);

  bos_op_t op_e;

  always_comb begin
    op_e       = bos_op_t'(op);
    take_jump  = (op_e == OP_JUMP);
    // fetched word is stale after a branch or a zero skip
    flush_next = take_jump || (bos_is_skip_op(op_e) && res_zero);
    // page bits above the immediate
    target     = {page, jump_k};
  end

endmodule : bos_seq
`default_nettype wire

/* File: core/bos_exec.sv */
// execution unit for byte file ops, zero skips, absolute jump and or-literal
`timescale 1ns/10ps
`default_nettype none
module bos_exec
  import bos_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // instruction stream
  input  wire logic               insn_valid,
  input  wire logic [INSN_W-1:0]  insn,
  input  wire logic [PAGE_W-1:0]  status_page,
  // file register read
  output logic      [FADDR_W-1:0] file_raddr,
  input  wire logic [DATA_W-1:0]  file_rdata,
  // file register write
  output logic                    file_we,
  output logic      [FADDR_W-1:0] file_waddr,
  output logic      [DATA_W-1:0]  file_wdata,
  // core state
  output logic      [DATA_W-1:0]  acc,
  output logic                    zero_flag,
  output logic                    pc_load,
  output logic      [PC_W-1:0]    pc_target,
  output logic                    nop_slot
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [DATA_W-1:0]  acc_q;
  logic [DATA_W-1:0]  acc_d;
  logic               zero_q;
  logic               zero_d;
  logic               nop_slot_q;
  logic               we_q;
  logic [FADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0]  wdata_q;
  logic               pc_load_q;
  logic [PC_W-1:0]    pc_target_q;

  bos_op_t            op;
  logic               dest_file;
  logic [FADDR_W-1:0] f_addr;
  logic [DATA_W-1:0]  f_val;
  logic [DATA_W-1:0]  alu_res;
  logic               alu_zero;
  logic               take_jump;
  logic               flush_next;
  logic [PC_W-1:0]    target;
  logic               to_file;
  logic               to_acc;
  logic               hits_zero;

  // ****************************************************************
  // decode
  // ****************************************************************
  always_comb begin
    // the word fetched behind a flush never executes
    op        = (insn_valid && !nop_slot_q) ? bos_decode(insn) : OP_NONE;
    dest_file = insn[FLD_DEST];
    f_addr    = insn[FLD_F_LSB +: FADDR_W];
    // a write still in flight is newer than the file's copy
    f_val     = (we_q && waddr_q == f_addr) ? wdata_q : file_rdata;
  end

  assign file_raddr = f_addr;

  always_comb begin
    to_file   = bos_is_file_op(op) && dest_file;
    to_acc    = (bos_is_file_op(op) && !dest_file) || (op == OP_OR_LIT);
    hits_zero = (op == OP_COMPLEMENT) || (op == OP_DECREMENT) ||
                (op == OP_INCREMENT) || (op == OP_OR_LIT);
  end

  // ****************************************************************
  // datapath units
  // ****************************************************************
  bos_alu u_alu (
    .op       (op),
    .file_val (f_val),
    .acc_val  (acc_q),
    .literal  (insn[FLD_K_LSB +: DATA_W]),
    .result   (alu_res),
    .is_zero  (alu_zero)
  );

  bos_seq u_seq (
    .op         (op),
    .res_zero   (alu_zero),
    .jump_k     (insn[FLD_K_LSB +: JMP_W]),
    .page       (status_page),
    .take_jump  (take_jump),
    .flush_next (flush_next),
    .target     (target)
  );

  // ****************************************************************
  // accumulator
  // ****************************************************************
  always_comb begin
    acc_d = to_acc ? alu_res : acc_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ****************************************************************
  // zero flag
  // ****************************************************************
  always_comb begin
    // skips and jumps fall through here and keep the flag
    zero_d = hits_zero ? alu_zero : zero_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zero_q <= ZERO_RST;
    end else begin
      zero_q <= zero_d;
    end
  end

  // ****************************************************************
  // file write-back
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      we_q    <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
    end else begin
      we_q <= to_file;
      if (to_file) begin
        waddr_q <= f_addr;
        wdata_q <= alu_res;
      end
    end
  end

  // ****************************************************************
  // flow control
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nop_slot_q <= 1'b0;
    end else begin
      nop_slot_q <= flush_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_load_q   <= 1'b0;
      pc_target_q <= PC_RST;
    end else begin
      pc_load_q <= take_jump;
      if (take_jump) begin
        pc_target_q <= target;
      end
    end
  end

  assign acc        = acc_q;
  assign zero_flag  = zero_q;
  assign file_we    = we_q;
  assign file_waddr = waddr_q;
  assign file_wdata = wdata_q;
  assign pc_load    = pc_load_q;
  assign pc_target  = pc_target_q;
  assign nop_slot   = nop_slot_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (sys_rst);

  logic [DATA_W-1:0] dest_val;
  assign dest_val = we_q ? wdata_q : acc_q;

  chk_complement_bits: assert property (
    op == OP_COMPLEMENT |=> dest_val == ~$past(f_val) && zero_q == (dest_val == 8'h00)
  ) else $error("complement result wrong");

  chk_dest_file_route: assert property (
    bos_is_file_op(op) && dest_file |=>
      we_q && waddr_q == $past(f_addr) && acc_q == $past(acc_q)
  ) else $error("file destination not honoured");

  chk_dest_acc_route: assert property (
    bos_is_file_op(op) && !dest_file |=> !we_q && acc_q == $past(alu_res)
  ) else $error("accumulator destination not honoured");

  chk_decrement_value: assert property (
    op == OP_DECREMENT |=> dest_val == $past(f_val) - 8'h01
  ) else $error("decrement result wrong");

  chk_increment_value: assert property (
    op == OP_INCREMENT |=> dest_val == $past(f_val) + 8'h01
  ) else $error("increment result wrong");

  chk_skip_keeps_flag: assert property (
    bos_is_skip_op(op) |=> $stable(zero_q)
  ) else $error("skip op touched the zero flag");

  chk_skip_step_dir: assert property (
    op == OP_INC_SKIP |=> dest_val == $past(f_val) + 8'h01
  ) else $error("increment-skip result wrong");

  chk_skip_slot_nop: assert property (
    bos_is_skip_op(op) && alu_zero |=> nop_slot_q ##1 !we_q && $stable(acc_q)
  ) else $error("skipped word was executed");

  chk_no_skip_nonzero: assert property (
    bos_is_skip_op(op) && !alu_zero |=> !nop_slot_q
  ) else $error("skip taken on a nonzero result");

  chk_jump_target_load: assert property (
    op == OP_JUMP |=> pc_load_q &&
      pc_target_q == {$past(status_page), $past(insn[FLD_K_LSB +: JMP_W])}
  ) else $error("jump target wrong");

  chk_jump_two_cycle: assert property (
    op == OP_JUMP |=> nop_slot_q && $stable(zero_q) ##1 !pc_load_q
  ) else $error("jump cycle count or flags wrong");

  chk_or_literal_acc: assert property (
    op == OP_OR_LIT |=> acc_q == ($past(acc_q) | $past(insn[FLD_K_LSB +: DATA_W]))
  ) else $error("or-literal result wrong");

  chk_zero_tracks_res: assert property (
    hits_zero |=> zero_q == ($past(alu_res) == 8'h00)
  ) else $error("zero flag disagrees with result");

  chk_dec_skip_value: assert property (
    op == OP_DEC_SKIP |=> dest_val == $past(f_val) - 8'h01
  ) else $error("decrement-skip result wrong");

  chk_inc_skip_route: assert property (
    op == OP_INC_SKIP |=> $stable(zero_q) && we_q == $past(dest_file)
  ) else $error("increment-skip touched the flag or missed its destination");

  chk_slot_no_effect: assert property (
    nop_slot_q |=> !we_q && !pc_load_q && !nop_slot_q &&
      $stable(acc_q) && $stable(zero_q)
  ) else $error("discarded word left an effect");

  chk_target_holds: assert property (
    op != OP_JUMP |=> !pc_load_q && $stable(pc_target_q)
  ) else $error("program counter target moved without a jump");

  chk_page_bits: assert property (
    op == OP_JUMP |=> pc_target_q[PC_W-1 -: PAGE_W] == $past(status_page)
  ) else $error("page bits not taken from page select");

  chk_jump_keeps_data: assert property (
    op == OP_JUMP |=> !we_q && $stable(acc_q)
  ) else $error("jump changed data state");

  chk_or_lit_no_write: assert property (
    op == OP_OR_LIT |=> !we_q && !nop_slot_q && zero_q == (acc_q == 8'h00)
  ) else $error("or-literal wrote a file or flushed");

  chk_dec_zero_flag: assert property (
    op == OP_DECREMENT |=> zero_q == (dest_val == 8'h00)
  ) else $error("decrement zero flag wrong");

  chk_inc_zero_flag: assert property (
    op == OP_INCREMENT |=> zero_q == (dest_val == 8'h00)
  ) else $error("increment zero flag wrong");

  chk_zero_held: assert property (
    !hits_zero |=> $stable(zero_q)
  ) else $error("zero flag moved without a flag-setting op");

  chk_acc_held: assert property (
    !to_acc |=> $stable(acc_q)
  ) else $error("accumulator changed without an accumulator result");

endmodule : bos_exec
`default_nettype wire

/* File: tb/test_bos_exec.sv */
// self-checking bench for the byte-op executor
`timescale 1ns/10ps
`default_nettype none
module test_bos_exec;
  import bos_pkg::*;

  // ****************************************************************
  // stimulus, file model, dut
  // ****************************************************************
  logic                clk         = 1'b0;
  logic                sys_rst     = 1'b1;
  logic                insn_valid  = 1'b0;
  logic [INSN_W-1:0]   insn        = 12'h000;
  logic [PAGE_W-1:0]   status_page = 2'h0;
  logic [FADDR_W-1:0]  file_raddr;
  logic [FADDR_W-1:0]  file_waddr;
  logic [DATA_W-1:0]   file_rdata;
  logic [DATA_W-1:0]   file_wdata;
  logic [DATA_W-1:0]   acc;
  logic                file_we;
  logic                zero_flag;
  logic                pc_load;
  logic                nop_slot;
  logic [PC_W-1:0]     pc_target;
  logic [DATA_W-1:0]   mem [32];
  logic [DATA_W-1:0]   acc_m = 8'h00;
  logic                z_m   = 1'b0;
  int                  fail_count  = 0;
  int                  comparisons = 0;

  always #2.5 clk = ~clk;

  assign file_rdata = mem[file_raddr];

  always @(posedge clk) begin
    if (file_we) mem[file_waddr] <= file_wdata;
  end

  bos_exec dut (
    .clk(clk), .sys_rst(sys_rst), .insn_valid(insn_valid), .insn(insn),
    .status_page(status_page), .file_raddr(file_raddr), .file_rdata(file_rdata),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .acc(acc), .zero_flag(zero_flag), .pc_load(pc_load),
    .pc_target(pc_target), .nop_slot(nop_slot)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one word per cycle; outputs are settled at the following falling edge
  task automatic step(input logic v, input logic [INSN_W-1:0] w);
    insn_valid = v;
    insn       = w;
    @(negedge clk);
  endtask : step

  task automatic file_case(input logic [5:0] op, input logic d, input logic [4:0] f,
                           input logic [7:0] val, input logic [7:0] res,
                           input logic skip_op);
    mem[f] = val;
    step(1'b1, {op, d, f});
    check(file_we, d);
    if (d) begin
      check(file_waddr, f);
      check(file_wdata, res);
    end else begin
      acc_m = res;
    end
    if (!skip_op) z_m = (res == 8'h00);
    check(acc, acc_m);
    check(zero_flag, z_m);
    check(nop_slot, skip_op && (res == 8'h00));
  endtask : file_case

  // word presented in the discarded slot must leave no trace
  task automatic dropped_slot(input logic [INSN_W-1:0] w);
    step(1'b1, w);
    check(file_we, 1'b0);
    check(pc_load, 1'b0);
    check(acc, acc_m);
    check(zero_flag, z_m);
    check(nop_slot, 1'b0);
  endtask : dropped_slot

  task automatic or_case(input logic [7:0] k);
    step(1'b1, {OPC_OR_LIT, k});
    acc_m = acc_m | k;
    z_m   = (acc_m == 8'h00);
    check(acc, acc_m);
    check(zero_flag, z_m);
  endtask : or_case

  task automatic jump_case(input logic [1:0] pg, input logic [8:0] k);
    status_page = pg;
    step(1'b1, {OPC_JUMP, k});
    check(pc_load, 1'b1);
    check(pc_target, {pg, k});
    check(nop_slot, 1'b1);
    check(zero_flag, z_m);
    dropped_slot({OPC_OR_LIT, 8'hFF});
  endtask : jump_case

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    check(acc, 8'h00);
    check(zero_flag, 1'b0);
    check(file_we, 1'b0);
    check(pc_load, 1'b0);
    check(pc_target, 11'h000);
    check(nop_slot, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // back to back, distinct addresses so no pending write aliases a preset
  task automatic t_file_ops;
    file_case(OPC_COMPLEMENT, 1'b0, 5'h00, 8'hFF, 8'h00, 1'b0);
    file_case(OPC_COMPLEMENT, 1'b1, 5'h1F, 8'h5A, 8'hA5, 1'b0);
    file_case(OPC_DECREMENT,  1'b0, 5'h02, 8'h01, 8'h00, 1'b0);
    file_case(OPC_DECREMENT,  1'b1, 5'h03, 8'h00, 8'hFF, 1'b0);
    file_case(OPC_INCREMENT,  1'b1, 5'h04, 8'hFF, 8'h00, 1'b0);
    file_case(OPC_INCREMENT,  1'b0, 5'h05, 8'h7F, 8'h80, 1'b0);
    $display("test file ops done");
  endtask : t_file_ops

  task automatic t_skips;
    file_case(OPC_DEC_SKIP, 1'b1, 5'h06, 8'h05, 8'h04, 1'b1);
    file_case(OPC_INC_SKIP, 1'b0, 5'h07, 8'h10, 8'h11, 1'b1);
    file_case(OPC_DEC_SKIP, 1'b0, 5'h08, 8'h01, 8'h00, 1'b1);
    dropped_slot({OPC_OR_LIT, 8'hFF});
    file_case(OPC_INC_SKIP, 1'b1, 5'h09, 8'hFF, 8'h00, 1'b1);
    dropped_slot({OPC_INCREMENT, 1'b1, 5'h0A});
    file_case(OPC_INCREMENT, 1'b0, 5'h0B, 8'h0F, 8'h10, 1'b0);
    $display("test skips done");
  endtask : t_skips

  task automatic t_jumps;
    jump_case(2'h2, 9'h1A5);
    jump_case(2'h3, 9'h1FF);
    jump_case(2'h1, 9'h000);
    // a jump word without valid must not load
    step(1'b0, {OPC_JUMP, 9'h0FF});
    check(pc_load, 1'b0);
    check(pc_target, 11'h200);
    $display("test jumps done");
  endtask : t_jumps

  task automatic t_or_literal;
    file_case(OPC_COMPLEMENT, 1'b0, 5'h0C, 8'hFF, 8'h00, 1'b0);
    or_case(8'h00);
    or_case(8'h30);
    step(1'b0, {OPC_OR_LIT, 8'h0F});
    check(acc, acc_m);
    or_case(8'h0F);
    or_case(8'hC0);
    $display("test or literal done");
  endtask : t_or_literal

  // reset in mid-run clears state built up by the earlier scenarios
  task automatic t_mid_reset;
    sys_rst = 1'b1;
    step(1'b1, {OPC_OR_LIT, 8'h55});
    t_reset();
    sys_rst = 1'b0;
    acc_m   = 8'h00;
    z_m     = 1'b0;
    or_case(8'h00);
    or_case(8'h81);
    $display("test mid-run reset done");
  endtask : t_mid_reset

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'h00;
    repeat (5) @(negedge clk);
    t_reset();
    sys_rst = 1'b0;
    t_file_ops();
    t_skips();
    t_jumps();
    t_or_literal();
    t_mid_reset();
    print_verdict();
  end

endmodule : test_bos_exec
`default_nettype wire
